// ### core/ibt_core.sv
// Two-wire bus byte transfer engine, master and slave, behind an Avalon-MM slave.
// Assumes open-drain pads outside: an oe high pulls the line low, out is always 0.
//
// Functional notes
// - Master transmit: data write sends byte, MSB first
// - Master receive: data read starts next byte
// - Slave transfers only after own address matched
// - Transfer starts only when direction matches access
// - Data read returns last received byte
// - First byte after master: address plus direction
// - START only on free bus, SDA falls
// - Address byte: seven bits then direction bit
// - Only matching slave acknowledges on ninth clock
// - No own address; arbitration loss becomes slave
// - Eight bits MSB first, ninth is acknowledge
// - No slave acknowledge shows as failed byte
// - Master nack ends slave transmit, SDA released
// - STOP frees bus; slave releases lines
// - Repeated START allowed without preceding STOP
// - Drive one, see zero: lose, flag, slave
// - Low time counted, high waits for SCL
// - Slave holds SCL low after full byte
// - Master accepts stretched SCL low periods
// - Lines only pulled low or released
// - Disabled after reset, no system reset
// - Master select makes START, clearing makes STOP
// - Direction bit: one transmit, zero receive
// - Byte flag cleared by matching data access
// - Byte flag set on ninth SCL fall
`timescale 1ns/1ps
module ibt_core import ibt_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Avalon-MM register slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Two-wire bus
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  ibt_line_t sync1, sync2, prev;
  ibt_ctl_t ctl;
  ibt_mstate_t m_state;
  logic [6:0] own_addr;
  logic [15:0] div_half, tcnt;
  logic rsta_req, byte_complete_flag, iaas, busy, arbitration_lost_flag, srw, rxak;
  logic xfer, eng_tx, eng_low, addr_cyc, skip_fall, sl_hold, ack_bit;
  logic [3:0] bitn;
  logic [7:0] shift, rx_data;
  logic m_ovr, m_sdalow, m_scllow, m_first, m_rs;
  logic scl_rise, scl_fall, start_det, stop_det, bus_take, wr_ok;
  logic ctl_wr, stat_wr, dat_wr, dat_rd, ready, launch_tx, launch_rx, own_call;
  logic fall9, match, arb_bit, arb_start, arb_stop, arb_rsta, arb_lost, rsta_take, tdone;
  logic [7:0] ctl_v, stat_v;

  // Line synchronisers and edge detection
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sync1 <= '1;
      sync2 <= '1;
      prev <= '1;
    end else begin
      sync1 <= '{scl: scl_in, sda: sda_in};
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  assign scl_rise = sync2.scl & ~prev.scl;
  assign scl_fall = ~sync2.scl & prev.scl;
  assign start_det = sync2.scl & prev.scl & prev.sda & ~sync2.sda;
  assign stop_det = sync2.scl & prev.scl & ~prev.sda & sync2.sda;

  // Bus access decode; a request is taken at the edge where waitrequest is low
  assign bus_take = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_ok = avs_write & bus_take & avs_byteenable[0];
  assign ctl_wr = wr_ok & (avs_address == OFS_CTL);
  assign stat_wr = wr_ok & (avs_address == OFS_STAT);
  assign dat_wr = wr_ok & (avs_address == OFS_DATA);
  assign dat_rd = avs_read & bus_take & (avs_address == OFS_DATA);

  // Transfer launch
  assign ready = ctl.en & ~xfer & ((ctl.master_select_bit & (m_state == M_HOLD)) | (~ctl.master_select_bit & iaas));
  assign own_call = ctl.master_select_bit & m_first & (avs_writedata[7:1] == own_addr);
  assign launch_tx = dat_wr & ctl.tx & ready & ~own_call;
  assign launch_rx = dat_rd & ~ctl.tx & ready & ~m_first;

  // Bus events and timer end used by the shifter, registers and master clock generator
  assign fall9 = xfer & ~skip_fall & scl_fall & (bitn == ACK_BIT);
  assign match = xfer & addr_cyc & ~eng_tx & ~ctl.master_select_bit & (shift[7:1] == own_addr);
  assign arb_bit = xfer & ctl.master_select_bit & scl_rise & ~eng_low & ~sync2.sda &
                   ((eng_tx & (bitn < ACK_BIT)) | (~eng_tx & (bitn == ACK_BIT)));
  assign arb_start = (m_state == M_IDLE) & ctl.en & ctl.master_select_bit & busy;
  assign arb_stop = stop_det & ctl.master_select_bit & (m_state != M_IDLE);
  assign arb_rsta = rsta_req & ~ctl.master_select_bit;
  assign arb_lost = arb_bit | arb_start | arb_stop | arb_rsta | (dat_wr & ctl.tx & ready & own_call);
  assign rsta_take = (m_state == M_HOLD) & rsta_req & ctl.master_select_bit & ~xfer;
  assign tdone = (tcnt >= div_half);

  always_comb begin
    ctl_v = '0;
    ctl_v[CTL_EN] = ctl.en;
    ctl_v[CTL_MST] = ctl.master_select_bit;
    ctl_v[CTL_TX] = ctl.tx;
    ctl_v[CTL_TXAK] = ctl.txak;
    stat_v = '0;
    stat_v[ST_TCF] = byte_complete_flag;
    stat_v[ST_IAAS] = iaas;
    stat_v[ST_BUSY] = busy;
    stat_v[ST_ARBITRATION_LOST_FLAG] = arbitration_lost_flag;
    stat_v[ST_SRW] = srw;
    stat_v[ST_RXAK] = rxak;
  end

  // Avalon handshake and read data
  always_ff @(posedge clock) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        case (avs_address)
          OFS_CTL: avs_readdata <= {24'h000000, ctl_v};
          OFS_STAT: avs_readdata <= {24'h000000, stat_v};
          OFS_DATA: avs_readdata <= {24'h000000, rx_data};
          OFS_ADDR: avs_readdata <= {25'h0000000, own_addr};
          OFS_DIV: avs_readdata <= {16'h0000, div_half};
          default: avs_readdata <= '0;
        endcase
      end
    end
  end

  // Control registers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctl <= '0;
      own_addr <= OWN_ADDR_RESET;
      div_half <= DIV_RESET;
      rsta_req <= 1'b0;
    end else begin
      if (ctl_wr) begin
        ctl.en <= avs_writedata[CTL_EN];
        ctl.master_select_bit <= avs_writedata[CTL_MST] & avs_writedata[CTL_EN];
        ctl.tx <= avs_writedata[CTL_TX];
        ctl.txak <= avs_writedata[CTL_TXAK];
      end
      if (wr_ok & (avs_address == OFS_ADDR)) begin
        own_addr <= avs_writedata[6:0];
      end
      if (wr_ok & (avs_address == OFS_DIV)) begin
        div_half <= avs_writedata[15:0];
      end
      if (arb_lost) begin
        ctl.master_select_bit <= 1'b0;
      end
      if (ctl_wr & avs_writedata[CTL_RSTA]) begin
        rsta_req <= 1'b1;
      end else if (rsta_take | arb_rsta) begin
        rsta_req <= 1'b0;
      end
    end
  end

  // Status flags; hardware set wins over software clear
  always_ff @(posedge clock) begin
    if (!nrst) begin
      byte_complete_flag <= 1'b0;
      iaas <= 1'b0;
      busy <= 1'b0;
      arbitration_lost_flag <= 1'b0;
      srw <= 1'b0;
      rxak <= 1'b0;
    end else begin
      if (fall9) begin
        byte_complete_flag <= 1'b1;
      end else if ((dat_rd & ~ctl.tx) | (dat_wr & ctl.tx)) begin
        byte_complete_flag <= 1'b0;
      end
      if (scl_fall & ~skip_fall & (bitn == LAST_DATA_BIT) & match) begin
        iaas <= 1'b1;
        srw <= shift[0];
      end else if (ctl_wr | stop_det) begin
        iaas <= 1'b0;
      end
      if (start_det) begin
        busy <= 1'b1;
      end else if (stop_det) begin
        busy <= 1'b0;
      end
      if (arb_lost) begin
        arbitration_lost_flag <= 1'b1;
      end else if (stat_wr & avs_writedata[ST_ARBITRATION_LOST_FLAG]) begin
        arbitration_lost_flag <= 1'b0;
      end
      if (xfer & scl_rise & (bitn == ACK_BIT) & eng_tx) begin
        rxak <= sync2.sda;
      end
    end
  end

  // Bit shifter shared by master and slave
  always_ff @(posedge clock) begin
    if (!nrst) begin
      xfer <= 1'b0;
      bitn <= '0;
      shift <= '0;
      rx_data <= '0;
      eng_tx <= 1'b0;
      eng_low <= 1'b0;
      addr_cyc <= 1'b0;
      skip_fall <= 1'b0;
      sl_hold <= 1'b0;
      ack_bit <= 1'b0;
    end else if (!ctl.en | stop_det) begin
      xfer <= 1'b0;
      eng_low <= 1'b0;
      sl_hold <= 1'b0;
      addr_cyc <= 1'b0;
    end else if (start_det & ~ctl.master_select_bit) begin
      xfer <= 1'b1;
      bitn <= '0;
      eng_tx <= 1'b0;
      eng_low <= 1'b0;
      addr_cyc <= 1'b1;
      skip_fall <= 1'b1;
      sl_hold <= 1'b0;
    end else if (launch_tx | launch_rx) begin
      xfer <= 1'b1;
      bitn <= '0;
      eng_tx <= ctl.tx;
      shift <= avs_writedata[7:0];
      eng_low <= launch_tx & ~avs_writedata[7];
      addr_cyc <= m_first & ctl.master_select_bit;
      skip_fall <= 1'b0;
      sl_hold <= 1'b0;
    end else if (xfer) begin
      if (arb_bit) begin
        eng_tx <= 1'b0;
        eng_low <= 1'b0;
      end
      if (scl_rise) begin
        if (bitn < ACK_BIT) begin
          shift <= {shift[6:0], sync2.sda};
        end else begin
          ack_bit <= sync2.sda;
        end
      end
      if (scl_fall & skip_fall) begin
        skip_fall <= 1'b0;
      end else if (scl_fall) begin
        bitn <= bitn + 4'h1;
        if (bitn < LAST_DATA_BIT) begin
          eng_low <= eng_tx & ~shift[7];
        end else if (bitn == LAST_DATA_BIT) begin
          if (eng_tx) begin
            eng_low <= 1'b0;
          end else if (addr_cyc) begin
            eng_low <= match;
            xfer <= match;
          end else begin
            eng_low <= ~ctl.txak;
            rx_data <= shift;
          end
        end else begin
          xfer <= 1'b0;
          bitn <= '0;
          eng_low <= 1'b0;
          addr_cyc <= 1'b0;
          sl_hold <= ~ctl.master_select_bit & (iaas | addr_cyc) & ~(eng_tx & ack_bit);
        end
      end
    end
  end

  // Master clock generator, START, STOP and repeated START
  always_ff @(posedge clock) begin
    if (!nrst) begin
      m_state <= M_IDLE;
      tcnt <= '0;
      m_ovr <= 1'b0;
      m_sdalow <= 1'b0;
      m_scllow <= 1'b0;
      m_first <= 1'b0;
      m_rs <= 1'b0;
    end else if (!ctl.en | arb_lost) begin
      m_state <= M_IDLE;
      tcnt <= '0;
      m_ovr <= 1'b0;
      m_scllow <= 1'b0;
      m_first <= 1'b0;
    end else begin
      tcnt <= tcnt + 16'h0001;
      unique case (m_state)
        M_IDLE: begin
          m_ovr <= 1'b0;
          tcnt <= '0;
          if (ctl.master_select_bit & ~busy) begin
            m_state <= M_START;
            m_ovr <= 1'b1;
            m_sdalow <= 1'b1;
          end
        end
        M_START: begin
          if (tdone) begin
            // SDA stays low until the first bit is set up under SCL low
            m_state <= M_HOLD;
            m_scllow <= 1'b1;
            m_first <= 1'b1;
          end
        end
        M_HOLD: begin
          tcnt <= '0;
          if (xfer) begin
            m_state <= M_LOW;
            m_first <= 1'b0;
            m_ovr <= 1'b0;
          end else if (!ctl.master_select_bit) begin
            m_state <= M_SEQA;
            m_ovr <= 1'b1;
            m_sdalow <= 1'b1;
            m_rs <= 1'b0;
          end else if (rsta_take) begin
            m_state <= M_SEQA;
            m_ovr <= 1'b1;
            m_sdalow <= 1'b0;
            m_rs <= 1'b1;
          end
        end
        M_LOW: begin
          if (!xfer) begin
            m_state <= M_HOLD;
          end else if (tdone) begin
            m_state <= M_HIGH;
            m_scllow <= 1'b0;
            tcnt <= '0;
          end
        end
        M_HIGH: begin
          if (!sync2.scl) begin
            tcnt <= '0;
          end else if (tdone) begin
            m_state <= M_LOW;
            m_scllow <= 1'b1;
            tcnt <= '0;
          end
        end
        M_SEQA: begin
          if (tdone) begin
            m_state <= M_SEQB;
            m_scllow <= 1'b0;
            tcnt <= '0;
          end
        end
        M_SEQB: begin
          if (!sync2.scl) begin
            tcnt <= '0;
          end else if (tdone) begin
            tcnt <= '0;
            m_sdalow <= m_rs;
            m_state <= m_rs ? M_SEQC : M_IDLE;
            m_ovr <= m_rs;
          end
        end
        M_SEQC: begin
          if (tdone) begin
            m_state <= M_HOLD;
            m_scllow <= 1'b1;
            m_first <= 1'b1;
          end
        end
      endcase
    end
  end

  // Open-drain pin drivers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end else begin
      sda_oe <= ctl.en & (m_ovr ? m_sdalow : eng_low);
      scl_oe <= ctl.en & (m_scllow | sl_hold);
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence ninth_fall_s;
    xfer && !skip_fall && scl_fall && bitn == ACK_BIT;
  endsequence

  sequence tx_launch_s;
    launch_tx && !avs_writedata[7];
  endsequence

  tcf_set_a: assert property (ninth_fall_s |=> byte_complete_flag) else $error("byte flag not set");
  tcf_clear_a: assert property (dat_wr && ctl.tx && !fall9 |=> !byte_complete_flag) else $error("byte flag kept");
  tx_start_a: assert property (tx_launch_s |=> xfer && eng_low ##1 sda_oe) else $error("msb not driven");
  dir_match_a: assert property (dat_rd && ctl.tx && !xfer |=> !xfer) else $error("receive started");
  rx_data_a: assert property (avs_read && avs_waitrequest && avs_address == OFS_DATA
                              |=> avs_readdata[7:0] == $past(rx_data)) else $error("bad read data");
  arb_drop_a: assert property (arb_bit |=> !ctl.master_select_bit && arbitration_lost_flag && m_state == M_IDLE ##1 !scl_oe)
              else $error("arbitration loss ignored");
  start_free_a: assert property ($rose(m_state == M_START) |-> !$past(busy)) else $error("start on busy");
  high_wait_a: assert property (m_state == M_HIGH && !sync2.scl |=> m_state == M_HIGH && tcnt == 16'h0000)
               else $error("high counted early");
  reset_off_a: assert property (@(posedge clock) disable iff (1'b0) !nrst |=> !ctl.en && !sda_oe && !scl_oe)
               else $error("enabled after reset");

endmodule

// ### core/ibt_pkg.sv
// Constants, register map and carrier types of the two-wire byte transfer engine.
// Assumes a 100 MHz module clock and a byte-addressed Avalon-MM register slave.
package ibt_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int HALF_BIT_NS = 5000;
  localparam int HALF_BIT_CYC = (HALF_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] DIV_RESET = 16'(HALF_BIT_CYC);

  // Register byte offsets
  localparam logic [4:0] OFS_CTL = 5'h00;
  localparam logic [4:0] OFS_STAT = 5'h04;
  localparam logic [4:0] OFS_DATA = 5'h08;
  localparam logic [4:0] OFS_ADDR = 5'h0C;
  localparam logic [4:0] OFS_DIV = 5'h10;

  // Control field positions
  localparam int CTL_EN = 7;
  localparam int CTL_MST = 5;
  localparam int CTL_TX = 4;
  localparam int CTL_TXAK = 3;
  localparam int CTL_RSTA = 2;

  // Status field positions
  localparam int ST_TCF = 7;
  localparam int ST_IAAS = 6;
  localparam int ST_BUSY = 5;
  localparam int ST_ARBITRATION_LOST_FLAG = 4;
  localparam int ST_SRW = 2;
  localparam int ST_RXAK = 0;

  localparam logic [6:0] OWN_ADDR_RESET = 7'h00;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

  typedef struct packed {
    logic en;
    logic master_select_bit;
    logic tx;
    logic txak;
  } ibt_ctl_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } ibt_line_t;

  typedef enum logic [7:0] {
    M_IDLE  = 8'h01,
    M_START = 8'h02,
    M_HOLD  = 8'h04,
    M_LOW   = 8'h08,
    M_HIGH  = 8'h10,
    M_SEQA  = 8'h20,
    M_SEQB  = 8'h40,
    M_SEQC  = 8'h80
  } ibt_mstate_t;

endpackage

// ### sim/ibt_slave_model.sv
// Behavioural slave on the open-drain two-wire bus, facing the byte transfer engine.
// Assumes resolved wire levels in; oe high pulls a line low, released lines float high.
`timescale 1ns/1ps
module ibt_slave_model #(
  parameter logic [6:0] ADDR = 7'h50,
  parameter int STRETCH_NS = 300
) (
  // Resolved bus lines
  input wire logic scl,
  input wire logic sda,
  // Byte returned on reads
  input wire logic [7:0] tx_byte,
  // Line pulls
  output logic scl_oe,
  output logic sda_oe,
  // Every byte clocked in
  output logic [7:0] rx_byte,
  output logic rx_done
);
  event ev_start;
  event ev_stop;
  logic again;

  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    rx_byte = 8'h00;
    rx_done = 1'b0;
    again = 1'b0;
  end

  always @(negedge sda) begin
    if (scl === 1'b1) -> ev_start;
  end

  always @(posedge sda) begin
    if (scl === 1'b1) -> ev_stop;
  end

  task automatic get_byte(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge scl);
      b = {b[6:0], sda};
    end
    @(negedge scl);
    rx_byte = b;
    rx_done = 1'b1;
    #1;
    rx_done = 1'b0;
  endtask

  task automatic give_ack(input logic hold);
    #30;
    sda_oe = 1'b1;
    @(posedge scl);
    @(negedge scl);
    #30;
    sda_oe = 1'b0;
    if (hold) begin
      scl_oe = 1'b1;
      #(STRETCH_NS);
      scl_oe = 1'b0;
    end
  endtask

  task automatic send_byte(input logic [7:0] t, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      #30;
      sda_oe = ~t[i];
      @(posedge scl);
      @(negedge scl);
    end
    #30;
    sda_oe = 1'b0;
    @(posedge scl);
    nack = sda;
    @(negedge scl);
  endtask

  task automatic run_frame();
    logic [7:0] b;
    logic nack;
    get_byte(b);
    if (b[7:1] !== ADDR) return;
    give_ack(!b[0]);
    if (b[0]) begin
      nack = 1'b0;
      while (!nack) send_byte(tx_byte, nack);
    end else begin
      forever begin
        get_byte(b);
        give_ack(1'b1);
      end
    end
  endtask

  // Frame runs until it returns or a STOP or a repeated START cuts it off
  always begin
    if (!again) @(ev_start);
    again = 1'b0;
    fork
      run_frame();
      @(ev_start) again = 1'b1;
      @(ev_stop);
    join_any
    disable fork;
    sda_oe = 1'b0;
    scl_oe = 1'b0;
  end
endmodule

// ### sim/testbench.sv
// Self-checking bench for the byte transfer engine as bus master against a slave model.
// Assumes the register map and timing of the package; divider set to 8 for a 210 ns bus clock (9 cycles low, 12 high).
`timescale 1ns/1ps
module testbench import ibt_pkg::*;;
  typedef struct {
    string name;
    logic [31:0] mask;
    logic [31:0] val;
  } ibt_exp_t;

  logic clock, nrst, avs_read, avs_write, avs_waitrequest, tb_sda_oe, rx_done;
  logic [4:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  logic dut_scl_out, dut_scl_oe, dut_sda_out, dut_sda_oe, sm_scl_oe, sm_sda_oe;
  logic [7:0] tx_byte, rx_byte, d;
  wire logic scl_w = !(dut_scl_oe | sm_scl_oe);
  wire logic sda_w = !(dut_sda_oe | sm_sda_oe | tb_sda_oe);
  int err_total, comparisons;
  ibt_exp_t rq[$];
  ibt_exp_t re;
  logic [7:0] mq[$];

  ibt_core u_dut (.clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_w),
    .scl_out(dut_scl_out), .scl_oe(dut_scl_oe), .sda_in(sda_w), .sda_out(dut_sda_out), .sda_oe(dut_sda_oe));

  ibt_slave_model #(.ADDR(7'h50), .STRETCH_NS(300)) u_model (.scl(scl_w), .sda(sda_w), .tx_byte(tx_byte),
    .scl_oe(sm_scl_oe), .sda_oe(sm_sda_oe), .rx_byte(rx_byte), .rx_done(rx_done));

  initial clock = 1'b0;
  always #5 clock = ~clock;

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic timeout(input string what);
    err_total++;
    $display("wrong value %s expected done seen timeout", what);
    end_sim();
  endtask

  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] wd, input string name,
                     input logic [31:0] mask, input logic [31:0] val);
    int n;
    ibt_exp_t e;
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    if (!w) begin
      e.name = name;
      e.mask = mask;
      e.val = val;
      rq.push_back(e);
    end
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) timeout("waitrequest");
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] wd);
    bus(a, 1'b1, wd, "", 32'h0, 32'h0);
  endtask

  task automatic rd(input logic [4:0] a, input string name, input logic [31:0] mask, input logic [31:0] val);
    bus(a, 1'b0, 32'h0, name, mask, val);
  endtask

  task automatic poll(input int bitn, input logic v);
    int n;
    n = 0;
    do begin
      rd(OFS_STAT, "", 32'h0, 32'h0);
      n++;
    end while (rdata[bitn] !== v && n < 400);
    if (rdata[bitn] !== v) timeout("status bit");
  endtask

  task automatic wait_scl(input logic v);
    int n;
    for (n = 0; n < 2000 && scl_w !== v; n++) @(posedge clock);
    if (scl_w !== v) timeout("bus clock");
  endtask

  task automatic send(input logic [7:0] v);
    mq.push_back(v);
    wr(OFS_DATA, {24'h0, v});
    rd(OFS_STAT, "flag cleared", 32'h80, 32'h0);
    poll(ST_TCF, 1'b1);
  endtask

  task automatic restart();
    wr(OFS_CTL, 32'hB4);
    wait_scl(1'b1);
    wait_scl(1'b0);
  endtask

  always @(posedge clock) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      re = rq.pop_front();
      if (re.mask != 32'h0) check(re.name, re.val & re.mask, avs_readdata & re.mask);
    end
  end

  always @(posedge rx_done) begin
    check("byte on bus", {24'h0, mq.pop_front()}, {24'h0, rx_byte});
  end

  initial begin
    nrst = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    tb_sda_oe = 1'b0;
    tx_byte = 8'h00;
    err_total = 0;
    comparisons = 0;
    d = 8'($urandom(32'hAA613969));
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    rd(OFS_CTL, "control", 32'hFF, 32'h0);
    rd(OFS_STAT, "status", 32'hFF, 32'h0);
    rd(OFS_DIV, "divider", 32'hFFFF, {16'h0, DIV_RESET});
    rd(5'h14, "unmapped", 32'hFFFFFFFF, 32'h0);
    check("line out", 32'h0, {30'h0, dut_scl_out, dut_sda_out});
    $display("test reset done");
    wr(OFS_DIV, 32'h8);
    wr(OFS_CTL, 32'hB0);
    poll(ST_BUSY, 1'b1);
    wait_scl(1'b0);
    send(8'hA0);
    rd(OFS_STAT, "address acked", 32'hB1, 32'hA0);
    d = 8'($urandom);
    send(d);
    rd(OFS_STAT, "data acked", 32'h81, 32'h80);
    $display("test transmit done");
    restart();
    send(8'h22);
    rd(OFS_STAT, "no ack", 32'h01, 32'h01);
    $display("test refused address done");
    d = 8'($urandom);
    tx_byte <= d;
    restart();
    send(8'hA1);
    rd(OFS_STAT, "read acked", 32'h01, 32'h0);
    wr(OFS_CTL, 32'hA8);
    rd(OFS_DATA, "", 32'h0, 32'h0);
    poll(ST_TCF, 1'b1);
    wr(OFS_CTL, 32'hB8);
    rd(OFS_DATA, "received byte", 32'hFF, {24'h0, d});
    rd(OFS_STAT, "flag kept", 32'h80, 32'h80);
    wr(OFS_CTL, 32'h80);
    poll(ST_BUSY, 1'b0);
    rd(OFS_CTL, "master bit", 32'h20, 32'h0);
    $display("test receive done");
    tb_sda_oe <= 1'b1;
    poll(ST_BUSY, 1'b1);
    wr(OFS_CTL, 32'hB0);
    poll(ST_ARBITRATION_LOST_FLAG, 1'b1);
    rd(OFS_CTL, "master after loss", 32'h20, 32'h0);
    check("sda pull after loss", 32'h0, {31'h0, dut_sda_oe});
    wr(OFS_STAT, 32'h10);
    rd(OFS_STAT, "lost cleared", 32'h10, 32'h0);
    tb_sda_oe <= 1'b0;
    poll(ST_BUSY, 1'b0);
    wr(OFS_CTL, 32'hB0);
    wait_scl(1'b0);
    wr(OFS_DATA, 32'hA0);
    tb_sda_oe <= 1'b1;
    poll(ST_ARBITRATION_LOST_FLAG, 1'b1);
    rd(OFS_CTL, "master after bit loss", 32'h20, 32'h0);
    rd(OFS_STAT, "busy after bit loss", 32'h20, 32'h20);
    check("sda pull after bit loss", 32'h0, {31'h0, dut_sda_oe});
    tb_sda_oe <= 1'b0;
    poll(ST_BUSY, 1'b0);
    $display("test arbitration done");
    end_sim();
  end
endmodule
